// *** hw/logic_eq_engine.sv ***
// Purpose: sequential evaluator for an array of configurable logic equations
// Assumes: ext_in are asynchronous pins; one equation evaluated per mclk
// Notes:   delays count in evaluation passes of NUM_EQ cycles each
`timescale 1ns/1ps
module logic_eq_engine (
    input  wire logic                                 mclk,
    input  wire logic                                 reset_n,
    input  wire logic [logic_eq_pkg::NUM_EXT-1:0]     ext_in,
    input  wire logic [logic_eq_pkg::ADDR_W-1:0]      reg_addr,
    input  wire logic [logic_eq_pkg::DATA_W-1:0]      reg_wdata,
    input  wire logic                                 reg_wr,
    input  wire logic                                 reg_rd,
    output logic      [logic_eq_pkg::DATA_W-1:0]      reg_rdata,
    output logic      [logic_eq_pkg::NUM_EQ-1:0]      eq_direct,
    output logic      [logic_eq_pkg::NUM_EQ-1:0]      eq_latched,
    output logic      [logic_eq_pkg::NUM_EQ-1:0]      eq_latched_n,
    output logic                                      pass_done
);
    import logic_eq_pkg::*;

    // ==========================================================
    // input synchroniser
    logic [NUM_EXT-1:0] ext_meta_ff;
    logic [NUM_EXT-1:0] ext_sync_ff;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ext_meta_ff <= '0;
            ext_sync_ff <= '0;
        end else begin
            ext_meta_ff <= ext_in;
            ext_sync_ff <= ext_meta_ff;
        end
    end

    // ==========================================================
    // configuration registers
    logic [23:0]      sel_ff   [NUM_EQ];
    logic [13:0]      ctrl_ff  [NUM_EQ];
    logic [31:0]      delay_ff [NUM_EQ];
    logic [23:0]      nxt_sel   [NUM_EQ];
    logic [13:0]      nxt_ctrl  [NUM_EQ];
    logic [31:0]      nxt_delay [NUM_EQ];

    logic             hit_eq;
    logic [EQ_IDX_W-1:0] reg_eq;
    logic [1:0]       reg_word;

    assign hit_eq   = (reg_addr < REG_EXT_IN);
    assign reg_eq   = reg_addr[EQ_IDX_W+1:2];
    assign reg_word = reg_addr[1:0];

    // one write decoder per equation; the status word takes no write
    for (genvar e = 0; e < NUM_EQ; e++) begin : g_cfg
        logic wr_hit;

        assign wr_hit = reg_wr && hit_eq && (reg_eq == EQ_IDX_W'(e));

        always_comb begin
            nxt_sel[e]   = sel_ff[e];
            nxt_ctrl[e]  = ctrl_ff[e];
            nxt_delay[e] = delay_ff[e];
            if (wr_hit) begin
                unique case (reg_word)
                    REG_EQ_SEL: begin
                        nxt_sel[e] = reg_wdata[23:0];
                    end
                    REG_EQ_CTRL: begin
                        nxt_ctrl[e] = reg_wdata[13:0];
                    end
                    REG_EQ_DELAY: begin
                        nxt_delay[e] = reg_wdata;
                    end
                    REG_EQ_STATUS: begin
                        nxt_sel[e] = sel_ff[e];
                    end
                endcase
            end
        end

        always_ff @(posedge mclk) begin
            if (!reset_n) begin
                sel_ff[e]   <= RST_SEL;
                ctrl_ff[e]  <= RST_CTRL;
                delay_ff[e] <= {RST_DELAY, RST_DELAY};
            end else begin
                sel_ff[e]   <= nxt_sel[e];
                ctrl_ff[e]  <= nxt_ctrl[e];
                delay_ff[e] <= nxt_delay[e];
            end
        end
    end

    // ==========================================================
    // equation state
    logic [EQ_IDX_W-1:0] idx_ff;
    logic [EQ_IDX_W-1:0] nxt_idx;
    logic [NUM_EQ-1:0]   dir_ff;
    logic [NUM_EQ-1:0]   lat_ff;
    logic [NUM_EQ-1:0]   nxt_dir;
    logic [NUM_EQ-1:0]   nxt_lat;
    logic [TMR_W-1:0]    cnt_ff [NUM_EQ];
    logic [TMR_W-1:0]    nxt_cnt [NUM_EQ];
    logic [3:0]          gin_ff  [NUM_EQ];
    logic [3:0]          nxt_gin [NUM_EQ];
    logic [NUM_EQ-1:0]   gate_ff;
    logic [NUM_EQ-1:0]   nxt_gate;
    logic [NUM_EQ-1:0]   rst_ff;
    logic [NUM_EQ-1:0]   nxt_rst;
    logic [15:0]         pass_cnt_ff;
    logic [15:0]         nxt_pass_cnt;
    logic                done_ff;
    logic                nxt_done;

    // source vector; the live dir/lat regs mean lower equations already
    // carry this pass's values and higher ones still the previous pass
    logic [NUM_SRC-1:0]  src;
    logic [63:0]         src_pad;
    assign src = {~lat_ff, lat_ff, dir_ff, ext_sync_ff};
    // codes past the last source read low, never unknown
    assign src_pad = {8'h00, src};

    // ==========================================================
    // one equation per cycle
    logic [23:0]      cur_sel;
    logic [13:0]      cur_ctrl;
    logic [TMR_W-1:0] on_dly;
    logic [TMR_W-1:0] off_dly;
    logic [3:0]       gin;
    logic             g;
    logic             clr;
    logic             tout;
    logic [TMR_W-1:0] cnt;
    gate_type         gsel;

    always_comb begin
        cur_sel  = sel_ff[idx_ff];
        cur_ctrl = ctrl_ff[idx_ff];
        on_dly   = delay_ff[idx_ff][TMR_W-1:0];
        off_dly  = delay_ff[idx_ff][2*TMR_W-1:TMR_W];
        gsel     = gate_type'(cur_ctrl[CTRL_GATE_LSB +: 3]);
    end

    // four selected, optionally inverted gate inputs
    for (genvar k = 0; k < 4; k++) begin : g_gin
        assign gin[k] = src_pad[cur_sel[k*SEL_W +: SEL_W]] ^ cur_ctrl[CTRL_INV_LSB + k];
    end

    // ==========================================================
    // gate
    always_comb begin
        unique case (gsel)
            GATE_AND:  g = &gin;
            GATE_OR:   g = |gin;
            GATE_NAND: g = ~&gin;
            GATE_NOR:  g = ~|gin;
            GATE_XOR:  g = ^gin;
            GATE_XNOR: g = ~^gin;
            GATE_PASS: g = gin[0];
            GATE_OFF:  g = 1'b0;
        endcase
    end

    assign clr = src_pad[cur_ctrl[CTRL_RSEL_LSB +: SEL_W]] ^ cur_ctrl[CTRL_RINV];

    // ==========================================================
    // timer: count passes while gate differs from output
    always_comb begin
        cnt  = cnt_ff[idx_ff];
        tout = dir_ff[idx_ff];
        // compare before counting, so a full-scale delay cannot wrap
        if (g == tout) begin
            cnt = '0;
        end else if (cnt >= (g ? on_dly : off_dly)) begin
            tout = g;
            cnt  = '0;
        end else begin
            cnt = cnt + 16'h0001;
        end
        for (int i = 0; i < NUM_EQ; i++) begin
            nxt_cnt[i] = cnt_ff[i];
        end
        nxt_cnt[idx_ff] = cnt;
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            for (int i = 0; i < NUM_EQ; i++) begin
                cnt_ff[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NUM_EQ; i++) begin
                cnt_ff[i] <= nxt_cnt[i];
            end
        end
    end

    // ==========================================================
    // outputs, latch and observed state
    always_comb begin
        nxt_dir  = dir_ff;
        nxt_lat  = lat_ff;
        nxt_gin  = gin_ff;
        nxt_gate = gate_ff;
        nxt_rst  = rst_ff;
        nxt_dir[idx_ff]  = tout;
        nxt_gin[idx_ff]  = gin;
        nxt_gate[idx_ff] = g;
        nxt_rst[idx_ff]  = clr;
        if (clr) begin
            nxt_lat[idx_ff] = 1'b0;
        end else if (tout) begin
            nxt_lat[idx_ff] = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            dir_ff  <= '0;
            lat_ff  <= '0;
            gate_ff <= '0;
            rst_ff  <= '0;
            for (int i = 0; i < NUM_EQ; i++) begin
                gin_ff[i] <= '0;
            end
        end else begin
            dir_ff  <= nxt_dir;
            lat_ff  <= nxt_lat;
            gate_ff <= nxt_gate;
            rst_ff  <= nxt_rst;
            for (int i = 0; i < NUM_EQ; i++) begin
                gin_ff[i] <= nxt_gin[i];
            end
        end
    end

    // ==========================================================
    // ascending scan that wraps forever
    always_comb begin
        nxt_idx      = idx_ff + EQ_IDX_W'(1);
        nxt_done     = (idx_ff == EQ_IDX_W'(NUM_EQ - 1));
        nxt_pass_cnt = nxt_done ? pass_cnt_ff + 16'h0001 : pass_cnt_ff;
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            idx_ff      <= '0;
            pass_cnt_ff <= '0;
            done_ff     <= 1'b0;
        end else begin
            idx_ff      <= nxt_idx;
            pass_cnt_ff <= nxt_pass_cnt;
            done_ff     <= nxt_done;
        end
    end

    // ==========================================================
    // outputs to relays and blockings
    assign eq_direct    = dir_ff;
    assign eq_latched   = lat_ff;
    assign eq_latched_n = ~lat_ff;
    assign pass_done    = done_ff;

    // ==========================================================
    // read port, data one cycle after the strobe
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] nxt_rdata;

    // status word per equation, gathered once for the read mux
    logic [DATA_W-1:0] status_word [NUM_EQ];

    for (genvar e = 0; e < NUM_EQ; e++) begin : g_status
        assign status_word[e] = {23'h000000, rst_ff[e], gate_ff[e], ~lat_ff[e],
                                 lat_ff[e], dir_ff[e], gin_ff[e]};
    end

    always_comb begin
        nxt_rdata = '0;
        if (reg_rd && hit_eq) begin
            unique case (reg_word)
                REG_EQ_SEL: begin
                    nxt_rdata = {8'h00, sel_ff[reg_eq]};
                end
                REG_EQ_CTRL: begin
                    nxt_rdata = {18'h00000, ctrl_ff[reg_eq]};
                end
                REG_EQ_DELAY: begin
                    nxt_rdata = delay_ff[reg_eq];
                end
                REG_EQ_STATUS: begin
                    nxt_rdata = status_word[reg_eq];
                end
            endcase
        end else if (reg_rd) begin
            case (reg_addr)
                REG_EXT_IN: begin
                    nxt_rdata = ext_sync_ff;
                end
                REG_OUT_ALL: begin
                    nxt_rdata = {8'h00, ~lat_ff, lat_ff, dir_ff};
                end
                REG_PASS_CNT: begin
                    nxt_rdata = {16'h0000, pass_cnt_ff};
                end
                default: begin
                    nxt_rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

endmodule

// *** hw/logic_eq_pkg.sv ***
// Purpose: shared constants and types for the logic equation engine
// Assumes: 25 MHz mclk, plain register port with read data one cycle later
// Notes:   all offsets are word indexes on the register port
package logic_eq_pkg;

    // ==========================================================
    // sizes
    localparam int NUM_EQ       = 8;
    localparam int EQ_IDX_W     = 3;
    localparam int NUM_EXT      = 32;
    localparam int SEL_W        = 6;
    localparam int NUM_SRC      = NUM_EXT + 3 * NUM_EQ;
    localparam int TMR_W        = 16;
    localparam int ADDR_W       = 8;
    localparam int DATA_W       = 32;

    // ==========================================================
    // register map: per-equation block of four words
    localparam logic [ADDR_W-1:0] REG_EQ_BASE   = 8'h00;
    localparam logic [1:0]        REG_EQ_SEL    = 2'h0;
    localparam logic [1:0]        REG_EQ_CTRL   = 2'h1;
    localparam logic [1:0]        REG_EQ_DELAY  = 2'h2;
    localparam logic [1:0]        REG_EQ_STATUS = 2'h3;
    localparam logic [ADDR_W-1:0] REG_EXT_IN    = 8'h20;
    localparam logic [ADDR_W-1:0] REG_OUT_ALL   = 8'h21;
    localparam logic [ADDR_W-1:0] REG_PASS_CNT  = 8'h22;

    // ==========================================================
    // ctrl field positions
    localparam int CTRL_INV_LSB  = 0;
    localparam int CTRL_RINV     = 4;
    localparam int CTRL_GATE_LSB = 5;
    localparam int CTRL_RSEL_LSB = 8;

    // ==========================================================
    // reset values
    localparam logic [23:0]      RST_SEL   = 24'h000000;
    localparam logic [13:0]      RST_CTRL  = 14'h0000;
    localparam logic [TMR_W-1:0] RST_DELAY = 16'h0000;

    // ==========================================================
    // source numbering: external inputs, then direct, latched, inverted
    localparam int SRC_DIRECT = NUM_EXT;
    localparam int SRC_LATCH  = NUM_EXT + NUM_EQ;
    localparam int SRC_NLATCH = NUM_EXT + 2 * NUM_EQ;

    typedef enum logic [2:0] {
        GATE_AND,
        GATE_OR,
        GATE_NAND,
        GATE_NOR,
        GATE_XOR,
        GATE_XNOR,
        GATE_PASS,
        GATE_OFF
    } gate_type;

endpackage

// *** verif/logic_eq_checker_asserts.sv ***
// Purpose: port-level checks on the logic equation engine
// Assumes: one mclk domain, synchronous active-low reset_n
// Notes:   bodies unseen, so every check ties ports together
`timescale 1ns/1ps
module logic_eq_checker
    import logic_eq_pkg::*;
(
    input wire logic                            mclk,
    input wire logic                            reset_n,
    input wire logic [logic_eq_pkg::ADDR_W-1:0] reg_addr,
    input wire logic                            reg_rd,
    input wire logic [logic_eq_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [logic_eq_pkg::NUM_EQ-1:0] eq_direct,
    input wire logic [logic_eq_pkg::NUM_EQ-1:0] eq_latched,
    input wire logic [logic_eq_pkg::NUM_EQ-1:0] eq_latched_n,
    input wire logic                            pass_done
);
    // ==========================================
    // properties
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    sequence s_quiet_pass;
        !pass_done [*7] ##1 pass_done;
    endsequence
    property p_pass_gap;
        pass_done |=> s_quiet_pass;
    endproperty
    property p_eq7_slot;
        $changed(eq_direct[NUM_EQ-1]) |-> pass_done;
    endproperty
    property p_one_eq;
        $countones((eq_direct ^ $past(eq_direct)) | (eq_latched ^ $past(eq_latched))) <= 1;
    endproperty
    property p_inv;
        eq_latched_n == ~eq_latched;
    endproperty
    // set only while the timer output is high
    property p_set;
        (eq_latched & ~$past(eq_latched) & ~eq_direct) == '0;
    endproperty
    property p_idle;
        !$past(reg_rd) |-> reg_rdata == '0;
    endproperty
    property p_unmapped;
        reg_rd && reg_addr > REG_PASS_CNT |=> reg_rdata == '0;
    endproperty
    property p_out_read;
        reg_rd && reg_addr == REG_OUT_ALL |=>
            reg_rdata == {8'h00, $past(eq_latched_n), $past(eq_latched), $past(eq_direct)};
    endproperty
    // reset itself is the antecedent, so no disable here
    property p_reset;
        disable iff (1'b0) !reset_n |=> eq_direct == '0 && eq_latched == '0 && eq_latched_n == '1 && !pass_done;
    endproperty
    a_pass_gap: assert property (p_pass_gap) else $error("pass spacing wrong");
    a_eq7_slot: assert property (p_eq7_slot) else $error("last equation out of slot");
    a_one_eq: assert property (p_one_eq) else $error("two equations changed at once");
    a_inv: assert property (p_inv) else $error("inverted latch mismatch");
    a_set: assert property (p_set) else $error("latch set without timer output");
    a_idle: assert property (p_idle) else $error("read data outside its cycle");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_out_read: assert property (p_out_read) else $error("output word mismatch");
    a_reset: assert property (p_reset) else $error("reset values wrong");
endmodule

// *** verif/ext_source.sv ***
// Purpose: far-side source of assignment-list levels
// Assumes: levels change just after mclk and hold until told otherwise
// Notes:   slow mode lags two cycles, like a late contact
`timescale 1ns/1ps
module ext_source (
    input  wire logic        mclk,
    input  wire logic        slow,
    input  wire logic [31:0] want,
    output logic      [31:0] ext_in
);
    logic [31:0] lag1;
    logic [31:0] lag2;
    initial ext_in = '0;
    always @(posedge mclk) begin
        lag1   <= want;
        lag2   <= lag1;
        ext_in <= slow ? lag2 : want;
    end
endmodule

// *** verif/tb.sv ***
// Purpose: self-checking bench for the logic equation engine
// Assumes: a pass is NUM_EQ cycles, delays count in passes
// Notes:   settled checks wait two passes to cover the input sync
`timescale 1ns/1ps
module tb;
    import logic_eq_pkg::*;
    logic               mclk, reset_n, reg_wr, reg_rd, pass_done, slow, ge;
    logic [ADDR_W-1:0]  reg_addr;
    logic [DATA_W-1:0]  reg_wdata, reg_rdata, v, seed;
    logic [NUM_EXT-1:0] ext_in, want;
    logic [NUM_EQ-1:0]  eq_direct, eq_latched, eq_latched_n;
    logic [3:0]         x, s;
    logic [3:0]         steps [6] = '{4'b1001, 4'b0001, 4'b1100, 4'b0000, 4'b1010, 4'b1111};
    int                 fails, n_checks;
    // ==========================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] a);
        a = a ^ (a << 13);
        a = a ^ (a >> 17);
        return a ^ (a << 5);
    endfunction
    function automatic logic gate_fn(input logic [2:0] g, input logic [3:0] i);
        case (g)
            3'h0: return &i;
            3'h1: return |i;
            3'h2: return ~&i;
            3'h3: return ~|i;
            3'h4: return ^i;
            3'h5: return ~^i;
            3'h6: return i[0];
            default: return 1'b0;
        endcase
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] o);
        n_checks++;
        if (o !== e) begin
            fails++;
            $display("BAD %s exp %h saw %h", nm, e, o);
        end
    endtask
    task automatic passes(input int n);
        repeat (n * NUM_EQ) @(posedge mclk);
        #1;
    endtask
    task automatic finish_test;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ==========================================
    // design and far side
    logic_eq_engine logic_eq_engine_inst (.mclk(mclk), .reset_n(reset_n), .ext_in(ext_in),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .eq_direct(eq_direct), .eq_latched(eq_latched),
        .eq_latched_n(eq_latched_n), .pass_done(pass_done));
    ext_source ext_source_inst (.mclk(mclk), .slow(slow), .want(want), .ext_in(ext_in));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // run is about 440 cycles
    initial begin
        repeat (6000) @(posedge mclk);
        fails++;
        finish_test;
    end
    // ==========================================
    // tests
    initial begin
        {reset_n, reg_wr, reg_rd, slow} = 4'h0;
        reg_addr = '0;
        reg_wdata = '0;
        want = '0;
        seed = 32'h5fe3;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        rd(8'h00);
        chk("sel", 32'(RST_SEL), v);
        rd(REG_OUT_ALL);
        chk("outs", 32'h00ff0000, v);
        rd(8'h40);
        chk("unmapped", 32'h0, v);
        $display("test reset done");
        wr(8'h00, 32'h000c2040);
        wr(8'h04, 32'd32);
        wr(8'h05, 32'h0c0);
        for (int g = 0; g < 8; g++) begin
            seed = xs(seed);
            x = seed[3:0];
            wr(8'h01, {24'h0, g[2:0], 1'b0, seed[7:4]});
            want[3:0] <= x;
            passes(2);
            ge = gate_fn(g[2:0], x ^ seed[7:4]);
            chk("eq0", 32'(ge), 32'(eq_direct[0]));
            chk("eq1", 32'(ge), 32'(eq_direct[1]));
            rd(8'h03);
            chk("status", 32'({ge, x ^ seed[7:4]}), 32'({v[7], v[3:0]}));
        end
        $display("test gates done");
        slow <= 1'b1;
        wr(8'h08, 32'd4);
        for (int i = 0; i < 6; i++) begin
            s = steps[i];
            wr(8'h09, 32'h5c0 | 32'({s[1], 4'h0}));
            want[5:4] <= {s[2], s[3]};
            passes(2);
            chk("latch", 32'(s[0]), 32'(eq_latched[2]));
            chk("latch_n", 32'(!s[0]), 32'(eq_latched_n[2]));
        end
        slow <= 1'b0;
        $display("test latch done");
        wr(8'h0c, 32'd6);
        wr(8'h0d, 32'h1fc0);
        wr(8'h0e, 32'h00020003);
        want[6] <= 1'b1;
        passes(2);
        chk("on early", 32'h0, 32'(eq_direct[3]));
        passes(5);
        chk("on late", 32'h1, 32'(eq_direct[3]));
        want[6] <= 1'b0;
        passes(1);
        chk("off early", 32'h1, 32'(eq_direct[3]));
        passes(5);
        chk("off late", 32'h0, 32'(eq_direct[3]));
        $display("test timer done");
        wr(8'h14, 32'd38);
        wr(8'h15, 32'h1fc0);
        wr(8'h18, 32'd7);
        wr(8'h19, 32'h1fc0);
        wr(8'h1c, 32'd38);
        wr(8'h1d, 32'h1fc0);
        passes(2);
        want[7] <= 1'b1;
        repeat (40) if (eq_direct[6] !== 1'b1) begin
            @(posedge mclk);
            #1;
        end
        @(posedge mclk);
        #1 chk("ascend", 32'h1, 32'(eq_direct[7]));
        repeat (5) @(posedge mclk);
        #1 chk("descend old", 32'h0, 32'(eq_direct[5]));
        @(posedge mclk);
        #1 chk("descend new", 32'h1, 32'(eq_direct[5]));
        rd(REG_EXT_IN);
        chk("ext", want, v);
        $display("test cascade done");
        finish_test;
    end
endmodule
bind logic_eq_engine logic_eq_checker logic_eq_checker_inst (.mclk(mclk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .eq_direct(eq_direct),
    .eq_latched(eq_latched), .eq_latched_n(eq_latched_n), .pass_done(pass_done));
